// File: rtl/tbf_pkg.sv
// Purpose: Shared constants and line carriers for the T1 code and link block
// Assumes: Register index = word address; byte address is four times it
// Notes:   Status registers are write-one-to-clear
package tbf_pkg;
    localparam int AW = 12;
    // Register indices
    localparam logic [9:0] IDX_RX_CODE_CTL = 10'h015;
    localparam logic [9:0] IDX_RX_LINK     = 10'h062;
    localparam logic [9:0] IDX_RX_CODE     = 10'h063;
    localparam logic [9:0] IDX_RX_STAT7    = 10'h096;
    localparam logic [9:0] IDX_RX_MASK7    = 10'h0A6;
    localparam logic [9:0] IDX_TX_PKT2     = 10'h113;
    localparam logic [9:0] IDX_TX_LINK     = 10'h162;
    localparam logic [9:0] IDX_TX_CODE     = 10'h163;
    localparam logic [9:0] IDX_TX_CTL1     = 10'h181;
    localparam logic [9:0] IDX_TX_CTL2     = 10'h182;
    localparam logic [9:0] IDX_TX_STAT2    = 10'h191;
    localparam logic [9:0] IDX_TX_MASK2    = 10'h1A1;
    // Field positions
    localparam int SEND_CODE_BIT = 6;
    localparam int PASS_BIT      = 6;
    localparam int SRC_SEL_BIT   = 7;
    localparam int DET_BIT       = 0;
    localparam int CLR_BIT       = 1;
    localparam int FULL_BIT      = 2;
    localparam int EMPTY_BIT     = 4;
    localparam int FILT_LSB      = 0;
    localparam int DIS_LSB       = 2;
    // Reset value and bus answers
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;
    // Last bit index of a link byte (eight bits in ESF, six in D4)
    localparam logic [2:0] ESF_LAST = 3'h7;
    localparam logic [2:0] D4_LAST  = 3'h5;
    // Code repetitions per filter setting, 4 bits each
    localparam logic [15:0] FILT_TAB = 16'h7531;
    // Silent slots per disintegration setting, 8 bits each
    localparam logic [31:0] DIS_TAB  = 32'h8040_2010;
    localparam logic [3:0]  BOC_ZERO0 = 4'h8;
    localparam logic [3:0]  BOC_ZERO1 = 4'hF;

    typedef struct packed {
        logic esf;
        logic slot;
        logic ser_fbit;
    } tbf_tx_line_s;

    typedef struct packed {
        logic esf;
        logic slot;
        logic dl_bit;
        logic mf_edge;
    } tbf_rx_line_s;
endpackage

// File: rtl/tbf_boc_fdl.sv
// Purpose: T1 bit-oriented code send/detect and byte-wide link access
// Assumes: Line strobes are synchronous to clk, one pulse per link bit
// Notes:   Latched flags are write-one-to-clear, a set in the clear cycle wins
`timescale 1ns/100ps
module tbf_boc_fdl (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [11:0]           awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [11:0]           araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire tbf_pkg::tbf_tx_line_s tx_line,
    input  wire tbf_pkg::tbf_rx_line_s rx_line,
    output logic                       tx_fbit_out,
    output logic                       interrupt_out_n
);
    import tbf_pkg::*;

    logic [7:0] code_ctl_q;
    logic [7:0] rx_link_q;
    logic [7:0] rx_code_q;
    logic [7:0] rx_stat_q;
    logic [7:0] rx_mask_q;
    logic [7:0] pkt2_q;
    logic [7:0] tx_link_q;
    logic [7:0] tx_code_q;
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [7:0] tx_stat_q;
    logic [7:0] tx_mask_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic       aw_rdy_q;
    logic       w_rdy_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic [9:0] wr_idx_q;
    logic [7:0] w_byte_q;
    logic       w_lane_q;
    logic       ar_rdy_q;
    logic       rvalid_q;
    logic [1:0] rresp_q;
    logic [7:0] rd_byte_q;
    logic       wr_go;
    logic       wr_we;
    logic [7:0] rd_mux;
    logic       rd_hit;
    logic       wr_hit;

    assign wr_go = ~aw_rdy_q & ~w_rdy_q & ~bvalid_q;
    assign wr_we = wr_go & w_lane_q & wr_hit;

    function automatic logic mapped(input logic [9:0] idx);
        unique case (idx)
            IDX_RX_CODE_CTL, IDX_RX_LINK, IDX_RX_CODE, IDX_RX_STAT7, IDX_RX_MASK7,
            IDX_TX_PKT2, IDX_TX_LINK, IDX_TX_CODE, IDX_TX_CTL1,
            IDX_TX_CTL2, IDX_TX_STAT2, IDX_TX_MASK2: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    assign wr_hit = mapped(wr_idx_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_rdy_q <= 1'b1;
            wr_idx_q <= 10'h000;
        end else if (awvalid && aw_rdy_q) begin
            aw_rdy_q <= 1'b0;
            wr_idx_q <= awaddr[11:2];
        end else if (bvalid_q && bready) begin
            aw_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_rdy_q  <= 1'b1;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else if (wvalid && w_rdy_q) begin
            w_rdy_q  <= 1'b0;
            w_byte_q <= wdata[7:0];
            w_lane_q <= wstrb[0];
        end else if (bvalid_q && bready) begin
            w_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OK;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OK : RESP_DEC;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = mapped(araddr[11:2]);
        unique case (araddr[11:2])
            IDX_RX_CODE_CTL: rd_mux = code_ctl_q;
            IDX_RX_LINK:     rd_mux = rx_link_q;
            IDX_RX_CODE:     rd_mux = rx_code_q;
            IDX_RX_STAT7:    rd_mux = rx_stat_q;
            IDX_RX_MASK7:    rd_mux = rx_mask_q;
            IDX_TX_PKT2:     rd_mux = pkt2_q;
            IDX_TX_LINK:     rd_mux = tx_link_q;
            IDX_TX_CODE:     rd_mux = tx_code_q;
            IDX_TX_CTL1:     rd_mux = ctl1_q;
            IDX_TX_CTL2:     rd_mux = ctl2_q;
            IDX_TX_STAT2:    rd_mux = tx_stat_q;
            IDX_TX_MASK2:    rd_mux = tx_mask_q;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ar_rdy_q  <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OK;
            rd_byte_q <= 8'h00;
        end else if (arvalid && ar_rdy_q) begin
            ar_rdy_q  <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_hit ? RESP_OK : RESP_DEC;
            rd_byte_q <= rd_mux;
        end else if (rvalid_q && rready) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign awready = aw_rdy_q;
    assign wready  = w_rdy_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = ar_rdy_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = {24'h000000, rd_byte_q};

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_ctl_q <= REG_RST;
            rx_mask_q  <= REG_RST;
            pkt2_q     <= REG_RST;
            tx_link_q  <= REG_RST;
            tx_code_q  <= REG_RST;
            ctl1_q     <= REG_RST;
            ctl2_q     <= REG_RST;
            tx_mask_q  <= REG_RST;
        end else if (wr_we) begin
            unique case (wr_idx_q)
                IDX_RX_CODE_CTL: code_ctl_q <= w_byte_q;
                IDX_RX_MASK7:    rx_mask_q  <= w_byte_q;
                IDX_TX_PKT2:     pkt2_q     <= w_byte_q;
                IDX_TX_LINK:     tx_link_q  <= w_byte_q;
                IDX_TX_CODE:     tx_code_q  <= {2'h0, w_byte_q[5:0]};
                IDX_TX_CTL1:     ctl1_q     <= w_byte_q;
                IDX_TX_CTL2:     ctl2_q     <= w_byte_q;
                IDX_TX_MASK2:    tx_mask_q  <= w_byte_q;
                default:         ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path
    logic       send_en;
    logic       send_en_q;
    logic       pass;
    logic       boc_on;
    logic       fdl_on;
    logic [3:0] boc_idx_q;
    logic       boc_bit;
    logic [2:0] tx_cnt_q;
    logic [7:0] tx_hold_q;
    logic [7:0] tx_cur;
    logic [2:0] tx_last;
    logic       fdl_bit;
    logic       tx_done;
    logic       fbit_q;

    assign send_en = pkt2_q[SEND_CODE_BIT];
    assign pass    = ctl1_q[PASS_BIT];
    assign boc_on  = send_en & tx_line.esf;
    assign fdl_on  = ~ctl2_q[SRC_SEL_BIT] & ~boc_on;
    assign tx_last = tx_line.esf ? ESF_LAST : D4_LAST;
    assign tx_cur  = (tx_cnt_q == 3'h0) ? tx_link_q : tx_hold_q;
    assign fdl_bit = tx_cur[tx_cnt_q];
    assign tx_done = tx_line.slot & fdl_on & (tx_cnt_q == tx_last);

    always_comb begin
        if (boc_idx_q < BOC_ZERO0) begin
            boc_bit = 1'b1;
        end else if (boc_idx_q == BOC_ZERO0 || boc_idx_q == BOC_ZERO1) begin
            boc_bit = 1'b0;
        end else begin
            boc_bit = tx_code_q[3'(boc_idx_q - 4'h9)];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            send_en_q <= 1'b0;
            boc_idx_q <= 4'h0;
        end else begin
            send_en_q <= send_en;
            if (send_en && !send_en_q) begin
                boc_idx_q <= 4'h0;
            end else if (tx_line.slot && boc_on) begin
                boc_idx_q <= boc_idx_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_cnt_q  <= 3'h0;
            tx_hold_q <= 8'h00;
        end else if (tx_line.slot && fdl_on) begin
            if (tx_cnt_q == 3'h0) begin
                tx_hold_q <= tx_link_q;
            end
            tx_cnt_q <= tx_done ? 3'h0 : tx_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fbit_q <= 1'b0;
        end else if (tx_line.slot) begin
            if (pass) begin
                fbit_q <= tx_line.ser_fbit;
            end else if (boc_on) begin
                fbit_q <= boc_bit;
            end else if (fdl_on) begin
                fbit_q <= fdl_bit;
            end else begin
                fbit_q <= tx_line.ser_fbit;
            end
        end
    end

    assign tx_fbit_out = fbit_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive link byte
    logic [7:0] rx_sh_q;
    logic [7:0] rx_sh_d;
    logic [2:0] rx_cnt_q;
    logic       rx_full;

    always_comb begin
        rx_sh_d = rx_sh_q;
        if (rx_line.slot) begin
            if (rx_line.esf) begin
                rx_sh_d = {rx_line.dl_bit, rx_sh_q[7:1]};
            end else begin
                rx_sh_d = {2'h0, rx_line.dl_bit, rx_sh_q[5:1]};
            end
        end
    end

    assign rx_full = rx_line.esf ? (rx_line.slot && rx_cnt_q == ESF_LAST)
                                 : rx_line.mf_edge;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sh_q   <= 8'h00;
            rx_cnt_q  <= 3'h0;
            rx_link_q <= REG_RST;
        end else begin
            rx_sh_q <= rx_sh_d;
            if (rx_line.slot) begin
                rx_cnt_q <= rx_cnt_q + 3'h1;
            end
            if (rx_full) begin
                rx_link_q <= rx_sh_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive code detector
    logic [15:0] win_q;
    logic [15:0] win_d;
    logic        esf_slot;
    logic        match;
    logic [5:0]  cand_q;
    logic [3:0]  rep_q;
    logic [3:0]  rep_d;
    logic [7:0]  gap_q;
    logic        act_q;
    logic [3:0]  thr;
    logic [7:0]  dis;
    logic        det_fire;
    logic        clr_fire;

    assign esf_slot = rx_line.slot & rx_line.esf;
    assign win_d    = {rx_line.dl_bit, win_q[15:1]};
    assign match    = (win_d[7:0] == 8'hFF) & ~win_d[8] & ~win_d[15];
    assign thr      = FILT_TAB[4*code_ctl_q[FILT_LSB +: 2] +: 4];
    assign dis      = DIS_TAB[8*code_ctl_q[DIS_LSB +: 2] +: 8];
    assign rep_d    = (win_d[14:9] != cand_q) ? 4'h1 :
                      (rep_q == 4'hF) ? rep_q : rep_q + 4'h1;
    assign det_fire = esf_slot & match & (rep_d == thr)
                    & (~act_q | (win_d[14:9] != rx_code_q[5:0]));
    assign clr_fire = esf_slot & ~match & act_q
                    & (gap_q + 8'h01 == dis);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_q  <= 16'h0000;
            cand_q <= 6'h00;
            rep_q  <= 4'h0;
            gap_q  <= 8'h00;
        end else if (esf_slot) begin
            win_q <= win_d;
            if (match) begin
                cand_q <= win_d[14:9];
                rep_q  <= rep_d;
                gap_q  <= 8'h00;
            end else begin
                if (gap_q != 8'hFF) begin
                    gap_q <= gap_q + 8'h01;
                end
                // Clear event re-arms the count so the same code can detect again
                if (clr_fire) begin
                    rep_q <= 4'h0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q     <= 1'b0;
            rx_code_q <= REG_RST;
        end else if (det_fire) begin
            act_q     <= 1'b1;
            rx_code_q <= {2'h0, win_d[14:9]};
        end else if (clr_fire) begin
            act_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched status, set wins over write-one clear
    logic [7:0] rx_stat_set;
    logic [7:0] rx_stat_clr;
    logic [7:0] tx_stat_set;
    logic [7:0] tx_stat_clr;

    always_comb begin
        rx_stat_set            = 8'h00;
        rx_stat_set[DET_BIT]   = det_fire;
        rx_stat_set[CLR_BIT]   = clr_fire;
        rx_stat_set[FULL_BIT]  = rx_full;
        tx_stat_set            = 8'h00;
        tx_stat_set[EMPTY_BIT] = tx_done;
        rx_stat_clr = (wr_we && wr_idx_q == IDX_RX_STAT7) ? w_byte_q : 8'h00;
        tx_stat_clr = (wr_we && wr_idx_q == IDX_TX_STAT2) ? w_byte_q : 8'h00;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_stat_q <= REG_RST;
            tx_stat_q <= REG_RST;
        end else begin
            rx_stat_q <= rx_stat_set | (rx_stat_q & ~rx_stat_clr);
            tx_stat_q <= tx_stat_set | (tx_stat_q & ~tx_stat_clr);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~(|(rx_stat_q & rx_mask_q) | |(tx_stat_q & tx_mask_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    int_drive_a: assert property (|(rx_stat_q & rx_mask_q) |=> !interrupt_out_n)
        else $error("masked receive flag did not pull interrupt low");
    empty_int_a: assert property (tx_done && tx_mask_q[EMPTY_BIT] |=> ##1 !interrupt_out_n)
        else $error("empty flag did not interrupt");
    det_load_a: assert property (det_fire |=> rx_stat_q[DET_BIT] && rx_code_q[5:0] == $past(win_d[14:9]))
        else $error("code detect did not latch flag and code");
    clr_set_a: assert property (clr_fire |=> rx_stat_q[CLR_BIT] && !act_q)
        else $error("code clear did not latch");
    full_set_a: assert property (esf_slot && rx_cnt_q == ESF_LAST |=> rx_stat_q[FULL_BIT])
        else $error("full flag missing after eighth bit");
    flag_bits_a: assert property (tx_line.slot && boc_on && !pass && boc_idx_q < BOC_ZERO0
                                  |=> tx_fbit_out)
        else $error("code flag bit not one");
    pass_thru_a: assert property (tx_line.slot && pass |=> tx_fbit_out == $past(tx_line.ser_fbit))
        else $error("pass-through bit wrong");
    fdl_out_a: assert property (tx_line.slot && fdl_on && !pass |=> tx_fbit_out == $past(fdl_bit))
        else $error("link byte bit wrong");
    esf_only_a: assert property (!rx_line.esf |=> $stable(win_q) && !rx_stat_set[DET_BIT])
        else $error("detector ran outside extended superframe");
endmodule

// File: tb/tbf_line_model.sv
// Purpose: Line side of the framer: link bit strobes, receive bits, transmit capture
// Assumes: One link bit every SLOT_GAP clocks; D4 multiframe carries six Fs bits
// Notes:   Receive bits cycle through rx_pat, 16 per period in ESF, 6 in D4
`timescale 1ns/100ps
module tbf_line_model #(
    parameter int SLOT_GAP = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             esf,
    input  wire logic             ser_bit,
    input  wire logic [15:0]      rx_pat,
    input  wire logic             tx_fbit_out,
    output tbf_pkg::tbf_tx_line_s tx_line,
    output tbf_pkg::tbf_rx_line_s rx_line,
    output logic [15:0]           tx_hist
);
    import tbf_pkg::*;
    logic [3:0] gap_q;
    logic [3:0] idx_q;
    logic       seen_q;
    logic       slot;
    assign slot = (gap_q == 4'(SLOT_GAP - 1));
    ////////////////////////////////////////
    // Newest transmitted bit enters at the top of the history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q   <= 4'h0;
            idx_q   <= 4'h0;
            seen_q  <= 1'b0;
            tx_hist <= 16'h0000;
        end else begin
            gap_q  <= slot ? 4'h0 : gap_q + 4'h1;
            seen_q <= slot;
            if (slot) begin
                idx_q <= (!esf && idx_q == 4'h5) ? 4'h0 : idx_q + 4'h1;
            end
            if (seen_q) begin
                tx_hist <= {tx_fbit_out, tx_hist[15:1]};
            end
        end
    end
    // Multiframe edge follows the sixth Fs bit by one clock
    always_comb begin
        tx_line = '{esf: esf, slot: slot, ser_fbit: ser_bit};
        rx_line = '{esf: esf, slot: slot, dl_bit: rx_pat[idx_q], mf_edge: seen_q && !esf && idx_q == 4'h0};
    end
endmodule

// File: tb/tbf_boc_fdl_tb_top.sv
// Purpose: Self-checking bench for the T1 code and link block
// Assumes: Line model strobes one link bit every four clocks
// Notes:   Registers reached over AXI4-Lite, byte address four times index
`timescale 1ns/100ps
module tbf_boc_fdl_tb_top;
    import tbf_pkg::*;
    logic         clk, rst, awvalid, wvalid, bready, arvalid, rready, esf, ser_bit;
    logic         awready, wready, bvalid, arready, rvalid, tx_fbit_out, interrupt_out_n;
    logic [11:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp, r;
    logic [15:0]  rx_pat, tx_hist;
    logic [7:0]   v;
    tbf_tx_line_s tx_line;
    tbf_rx_line_s rx_line;
    int           fails, checked;
    tbf_boc_fdl DUT (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_line, .rx_line,
        .tx_fbit_out, .interrupt_out_n);
    tbf_line_model LINE (.clk, .rst, .esf, .ser_bit, .rx_pat, .tx_fbit_out, .tx_line, .rx_line, .tx_hist);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] val, input logic [1:0] er = RESP_OK);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(16'({bvalid, bresp}), 16'({1'b1, er}));
        // Let an edge pass so the next call never re-drives bready in this step
        @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] idx, output logic [7:0] val, output logic [1:0] rs);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        val = rdata[7:0];
        rs  = rresp;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        rd(idx, v, r);
        chk({6'h0, r, v}, {6'h0, RESP_OK, e});
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (interrupt_out_n !== 1'b0 && n < 400);
        chk(16'(interrupt_out_n), 16'h0);
    endtask
    task automatic ackw(input logic [9:0] idx, input logic [7:0] m);
        wr(idx, m);
        wait_irq();
    endtask
    ////////////////////////////////////////
    task automatic s_regs();
        rdc(IDX_RX_CODE_CTL, REG_RST);
        rdc(IDX_TX_LINK, REG_RST);
        rdc(IDX_TX_MASK2, REG_RST);
        wr(IDX_RX_LINK, 8'h55);
        rdc(IDX_RX_LINK, 8'h00);
        wr(10'h3FF, 8'h01, RESP_DEC);
        rd(10'h3FF, v, r);
        chk({6'h0, r, v}, {6'h0, RESP_DEC, 8'h00});
        wr(IDX_RX_CODE_CTL, 8'h0F);
        rdc(IDX_RX_CODE_CTL, 8'h0F);
        wr(IDX_RX_CODE_CTL, 8'h00);
    endtask
    task automatic s_txlink();
        wr(IDX_TX_LINK, 8'hA5);
        wr(IDX_TX_MASK2, 8'h10);
        repeat (2) ackw(IDX_TX_STAT2, 8'h10);
        chk(16'(tx_hist[15:8]), 16'h00A5);
        ackw(IDX_TX_STAT2, 8'h10);
        chk(16'(tx_hist[15:8]), 16'h00A5);
        wr(IDX_TX_LINK, 8'hFF);
        repeat (2) ackw(IDX_TX_STAT2, 8'h10);
        chk(16'(tx_hist[15:8]), 16'h00FF);
        wr(IDX_TX_MASK2, 8'h00);
        wr(IDX_TX_STAT2, 8'h10);
        repeat (80) @(posedge clk);
        chk(16'(interrupt_out_n), 16'h1);
        rdc(IDX_TX_STAT2, 8'h10);
    endtask
    task automatic s_code();
        logic ok;
        ok = 1'b0;
        wr(IDX_TX_CODE, 8'hD5);
        wr(IDX_TX_PKT2, 8'h40);
        repeat (160) @(posedge clk);
        for (int i = 0; i < 16; i++) ok |= (16'({tx_hist, tx_hist} >> i) === 16'h2AFF);
        chk(16'(ok), 16'h1);
        wr(IDX_TX_CTL1, 8'h40);
        repeat (80) @(posedge clk);
        chk(tx_hist, 16'h0000);
        wr(IDX_TX_CTL1, 8'h00);
        wr(IDX_TX_PKT2, 8'h00);
    endtask
    task automatic s_rxcode();
        rx_pat <= 16'h54FF;
        wr(IDX_RX_STAT7, 8'h07);
        wr(IDX_RX_MASK7, 8'h01);
        wait_irq();
        rdc(IDX_RX_CODE, 8'h2A);
        wr(IDX_RX_STAT7, 8'h01);
        repeat (200) @(posedge clk);
        rd(IDX_RX_STAT7, v, r);
        chk(16'(v[DET_BIT]), 16'h0);
        rx_pat <= 16'h0000;
        wr(IDX_RX_STAT7, 8'h02);
        wr(IDX_RX_MASK7, 8'h02);
        wait_irq();
        rx_pat <= 16'h54FF;
        wr(IDX_RX_CODE_CTL, 8'h05);
        wr(IDX_RX_STAT7, 8'h03);
        wr(IDX_RX_MASK7, 8'h01);
        wait_irq();
        wr(IDX_RX_MASK7, 8'h00);
    endtask
    task automatic s_rxlink();
        rx_pat <= 16'h3131;
        wr(IDX_RX_MASK7, 8'h04);
        repeat (2) ackw(IDX_RX_STAT7, 8'h07);
        rdc(IDX_RX_LINK, 8'h31);
    endtask
    task automatic s_d4();
        esf <= 1'b0;
        rx_pat <= 16'h0029;
        wr(IDX_TX_LINK, 8'hDC);
        wr(IDX_RX_MASK7, 8'h00);
        wr(IDX_TX_MASK2, 8'h10);
        repeat (3) ackw(IDX_TX_STAT2, 8'h10);
        chk(16'(tx_hist[15:10]), 16'h001C);
        wr(IDX_TX_MASK2, 8'h00);
        wr(IDX_RX_MASK7, 8'h04);
        repeat (3) ackw(IDX_RX_STAT7, 8'h07);
        rdc(IDX_RX_LINK, 8'h29);
    endtask
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        print_verdict();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, ser_bit, awaddr, araddr, wdata, rx_pat} = '0;
        {fails, checked} = '0;
        wstrb = 4'hF;
        esf   = 1'b1;
        rst   = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_regs();
        s_txlink();
        s_code();
        s_rxcode();
        s_rxlink();
        s_d4();
        print_verdict();
    end
endmodule
